//--- core/rx_port_cfg.sv
// port mode, enable, paging, alias and forwarding register bank
// Notes on behaviour
// - strap level 0/4 csi-2, 1/5 raw12 low, 2/6 raw12 high, 3/7 raw10.
// - setup bits 1:0 show the strapped format and a write overrides it.
// - a reference with no transition for over 20 us is flagged lost.
// - until a reference is seen the 25 MHz backup oscillator is used.
// - the input enable register holds one enable bit per receive port.
// - remote master writes to the input enables are ignored.
// - page select picks the port whose registers a paged access reaches.
// - each remote path's page select resets to its own port; the local path's resets to port 0.
// - four 7-bit alias addresses each reach one port without paging.
// - an alias address reaches every shared register like the main one.
// - forwarding is off after reset; a port starts when its bit is set.
// - word clock is 4x ref, 2x ser, pix/2, 2/3 pix or pix by format.
// - each port is set to csi-2 or raw on its own, driving its receiver.
`timescale 1ns/1ps
`default_nettype none
`include "rx_port_cfg_map.svh"
module rx_port_cfg
  import rx_port_cfg_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h30
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // pins
  input  wire logic [2:0]  mode_strap,
  input  wire logic        reference_clock_in,
  // register access from the i2c target
  input  wire logic        acc_valid,
  input  wire logic        acc_write,
  input  wire logic        acc_local,
  input  wire logic [1:0]  acc_port,
  input  wire logic [6:0]  acc_i2c_addr,
  input  wire logic [7:0]  acc_reg,
  input  wire logic [7:0]  acc_wdata,
  output logic             acc_ack,
  output logic             acc_nak,
  output logic [7:0]       acc_rdata,
  // per-port controls
  output logic [3:0]       rx_input_en,
  output logic [3:0]       fwd_en,
  output logic [3:0]       port_raw_mode,
  output logic [7:0]       link_input_format,
  output logic [7:0]       wclk_src,
  output logic [11:0]      wclk_mul,
  output logic [7:0]       wclk_div,
  // clock status
  output logic             reference_clock_in_lost,
  output logic             use_ref_clk
);

  if (DEV_ADDR == 7'h00) begin : g_bad_addr
    $error("DEV_ADDR must be nonzero");
  end

  localparam logic [9:0] GAP_CYC = 10'(`REF_GAP_CYC);
  logic [2:0] strap_s1;
  logic [2:0] strap_s2;
  logic [1:0] strap_cnt;
  logic       ref_s1, ref_s2, ref_s3, ref_edge;
  logic [9:0] gap_cnt;
  logic [1:0] fmt       [4];
  logic       nonsync   [4];
  logic [7:0] alias_reg [4];
  logic [3:0] pg_wmask  [5];
  logic [1:0] pg_rsel   [5];
  logic       main_hit, alias_hit, hit, wr;
  logic [1:0] alias_port;
  logic [2:0] path;
  logic [3:0] tgt_mask;
  logic [1:0] tgt_rsel;
  logic [7:0] next_rdata;

  // pin synchronisers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      strap_s1 <= 3'h0;
      strap_s2 <= 3'h0;
      ref_s1   <= 1'b0;
      ref_s2   <= 1'b0;
      ref_s3   <= 1'b0;
    end else begin
      strap_s1 <= mode_strap;
      strap_s2 <= strap_s1;
      ref_s1   <= reference_clock_in;
      ref_s2   <= ref_s1;
      ref_s3   <= ref_s2;
    end
  end

  assign ref_edge = ref_s2 ^ ref_s3;

  // reference clock gap monitor
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      gap_cnt     <= GAP_CYC;
      reference_clock_in_lost <= 1'b1;
      use_ref_clk <= 1'b0;
    end else begin
      if (ref_edge) begin
        gap_cnt <= 10'h000;
      end else if (gap_cnt != GAP_CYC) begin
        gap_cnt <= gap_cnt + 10'h001;
      end
      reference_clock_in_lost <= !ref_edge && (gap_cnt == GAP_CYC);
      if (ref_edge) begin
        use_ref_clk <= 1'b1;
      end else if (gap_cnt == GAP_CYC) begin
        use_ref_clk <= 1'b0;
      end
    end
  end

  // strap capture after reset release
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      strap_cnt <= `STRAP_WAIT_CYC;
    end else if (strap_cnt != 2'h0) begin
      strap_cnt <= strap_cnt - 2'h1;
    end
  end

  // address decode
  always_comb begin
    alias_hit  = 1'b0;
    alias_port = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (alias_reg[i][7:`ALIAS_ADDR_LSB] == acc_i2c_addr &&
          alias_reg[i][7:`ALIAS_ADDR_LSB] != 7'h00) begin
        alias_hit  = 1'b1;
        alias_port = 2'(i);
      end
    end
    main_hit = (acc_i2c_addr == DEV_ADDR);
    hit      = main_hit || alias_hit;
    path     = acc_local ? `LOCAL_PATH : {1'b0, acc_port};
    if (alias_hit && !main_hit) begin
      tgt_mask = 4'h1 << alias_port;
      tgt_rsel = alias_port;
    end else begin
      tgt_mask = pg_wmask[path];
      tgt_rsel = pg_rsel[path];
    end
    wr = acc_valid && acc_write && hit;
  end

  // read mux
  always_comb begin
    next_rdata = 8'h00;
    unique case (acc_reg)
      `OFS_RX_INPUT_EN: next_rdata = {4'h0, rx_input_en};
      `OFS_STREAM_FWD:  next_rdata = {4'h0, fwd_en};
      `OFS_PAGE_SEL:    next_rdata = {2'h0, pg_rsel[path], pg_wmask[path]};
      `OFS_PORT_SETUP:  next_rdata = {5'h00, nonsync[tgt_rsel],
                                      fmt[tgt_rsel]};
      default:
        if (acc_reg >= `OFS_ALIAS0 && acc_reg <= `OFS_ALIAS3)
          next_rdata = alias_reg[2'(acc_reg - `OFS_ALIAS0)];
    endcase
  end

  // access answer
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      acc_ack   <= 1'b0;
      acc_nak   <= 1'b0;
      acc_rdata <= 8'h00;
    end else begin
      acc_ack   <= acc_valid && hit;
      acc_nak   <= acc_valid && !hit;
      acc_rdata <= (acc_valid && hit && !acc_write) ? next_rdata : 8'h00;
    end
  end

  // shared registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rx_input_en <= `RST_RX_INPUT_EN;
      fwd_en      <= `RST_STREAM_FWD;
    end else if (wr) begin
      if (acc_reg == `OFS_RX_INPUT_EN && acc_local) begin
        rx_input_en <= acc_wdata[3:0];
      end
      if (acc_reg == `OFS_STREAM_FWD) begin
        fwd_en <= acc_wdata[3:0];
      end
    end
  end

  // page select per access path
  genvar p;
  generate
    for (p = 0; p < 5; p++) begin : g_page
      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          pg_wmask[p] <= (p == 4) ? 4'h1 : 4'(1 << p);
          pg_rsel[p]  <= (p == 4) ? 2'h0 : 2'(p);
        end else if (wr && acc_reg == `OFS_PAGE_SEL && path == 3'(p)) begin
          pg_wmask[p] <= acc_wdata[`PAGE_RSEL_LSB-1:`PAGE_WMASK_LSB];
          pg_rsel[p]  <= acc_wdata[`PAGE_RSEL_LSB+1:`PAGE_RSEL_LSB];
        end
      end
    end
  endgenerate

  // per-port setup, alias and word clock derivation
  generate
    for (p = 0; p < 4; p++) begin : g_port
      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          fmt[p]     <= FMT_CSI2;
          nonsync[p] <= 1'b0;
        end else if (wr && acc_reg == `OFS_PORT_SETUP && tgt_mask[p]) begin
          fmt[p]     <= acc_wdata[`SETUP_FMT_LSB+1:`SETUP_FMT_LSB];
          nonsync[p] <= acc_wdata[`SETUP_NONSYNC_BIT];
        end else if (strap_cnt == 2'h1) begin
          fmt[p] <= strap_s2[1:0];
        end
      end
      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          alias_reg[p] <= `RST_ALIAS;
        end else if (wr && acc_reg == `OFS_ALIAS0 + 8'(p)) begin
          alias_reg[p] <= acc_wdata;
        end
      end
      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          link_input_format[2*p+:2] <= FMT_CSI2;
          port_raw_mode[p]          <= 1'b0;
          wclk_src[2*p+:2]          <= WCLK_REF;
          wclk_mul[3*p+:3]          <= 3'h4;
          wclk_div[2*p+:2]          <= 2'h1;
        end else begin
          link_input_format[2*p+:2] <= fmt[p];
          port_raw_mode[p]          <= (fmt[p] != FMT_CSI2);
          unique case (fmt[p])
            FMT_CSI2: begin
              wclk_src[2*p+:2] <= nonsync[p] ? WCLK_SER : WCLK_REF;
              wclk_mul[3*p+:3] <= nonsync[p] ? 3'h2 : 3'h4;
              wclk_div[2*p+:2] <= 2'h1;
            end
            FMT_RAW10: begin
              wclk_src[2*p+:2] <= WCLK_PIX;
              wclk_mul[3*p+:3] <= 3'h1;
              wclk_div[2*p+:2] <= 2'h2;
            end
            FMT_RAW12_HI: begin
              wclk_src[2*p+:2] <= WCLK_PIX;
              wclk_mul[3*p+:3] <= 3'h2;
              wclk_div[2*p+:2] <= 2'h3;
            end
            FMT_RAW12_LO: begin
              wclk_src[2*p+:2] <= WCLK_PIX;
              wclk_mul[3*p+:3] <= 3'h1;
              wclk_div[2*p+:2] <= 2'h1;
            end
          endcase
        end
      end
    end
  endgenerate

  // checks
  sequence s_strap_load;
    strap_cnt == 2'h1 && !(wr && acc_reg == `OFS_PORT_SETUP);
  endsequence
  property p_strap_load;
    @(posedge core_clk) disable iff (sys_rst)
      s_strap_load |=> fmt[0] == $past(strap_s2[1:0]) &&
                       fmt[3] == $past(strap_s2[1:0]);
  endproperty
  a_strap_load: assert property (p_strap_load)
    else $error("strap not loaded into port format");
  property p_setup_write;
    @(posedge core_clk) disable iff (sys_rst)
      wr && acc_reg == `OFS_PORT_SETUP && tgt_mask[1]
      |=> fmt[1] == $past(acc_wdata[1:0]);
  endproperty
  a_setup_write: assert property (p_setup_write)
    else $error("setup write did not override format");
  property p_remote_en;
    @(posedge core_clk) disable iff (sys_rst)
      wr && acc_reg == `OFS_RX_INPUT_EN && !acc_local
      |=> $stable(rx_input_en);
  endproperty
  a_remote_en: assert property (p_remote_en)
    else $error("remote write changed input enables");
  property p_local_en;
    @(posedge core_clk) disable iff (sys_rst)
      wr && acc_reg == `OFS_RX_INPUT_EN && acc_local
      |=> rx_input_en == $past(acc_wdata[3:0]);
  endproperty
  a_local_en: assert property (p_local_en)
    else $error("local write missed input enables");
  property p_fwd_reset;
    @(posedge core_clk) sys_rst |=> fwd_en == 4'h0 && pg_rsel[1] == 2'h1;
  endproperty
  a_fwd_reset: assert property (p_fwd_reset)
    else $error("forwarding or page select wrong after reset");
  property p_nak;
    @(posedge core_clk) disable iff (sys_rst)
      acc_valid && !hit |=> acc_nak && !acc_ack;
  endproperty
  a_nak: assert property (p_nak)
    else $error("unmatched address not refused");
  property p_ref_loss;
    @(posedge core_clk) disable iff (sys_rst)
      gap_cnt == GAP_CYC && !ref_edge |=> reference_clock_in_lost && !use_ref_clk;
  endproperty
  a_ref_loss: assert property (p_ref_loss)
    else $error("reference gap not flagged");
  property p_ref_use;
    @(posedge core_clk) disable iff (sys_rst)
      ref_edge |=> use_ref_clk ##1 (use_ref_clk || reference_clock_in_lost);
  endproperty
  a_ref_use: assert property (p_ref_use)
    else $error("reference clock not taken up");
  sequence s_raw10;
    fmt[2] == FMT_RAW10 ##1 fmt[2] == FMT_RAW10;
  endsequence
  property p_raw10_clk;
    @(posedge core_clk) disable iff (sys_rst)
      s_raw10 |-> wclk_src[5:4] == WCLK_PIX && wclk_div[5:4] == 2'h2 &&
                  port_raw_mode[2];
  endproperty
  a_raw10_clk: assert property (p_raw10_clk)
    else $error("raw10 word clock wrong");

endmodule : rx_port_cfg
`default_nettype wire

//--- shared/rx_port_cfg_map.svh
// offsets, fields, reset values and timing counts of the port setup bank
`ifndef RX_PORT_CFG_MAP_SVH
`define RX_PORT_CFG_MAP_SVH
`define OFS_RX_INPUT_EN     8'h0C
`define OFS_STREAM_FWD      8'h20
`define OFS_PAGE_SEL        8'h4C
`define OFS_PORT_SETUP      8'h6D
`define OFS_ALIAS0          8'hF8
`define OFS_ALIAS3          8'hFB
`define RST_RX_INPUT_EN     4'hF
`define RST_STREAM_FWD      4'h0
`define RST_ALIAS           8'h00
`define LOCAL_PATH          3'h4
`define PAGE_WMASK_LSB      0
`define PAGE_RSEL_LSB       4
`define SETUP_FMT_LSB       0
`define SETUP_NONSYNC_BIT   2
`define ALIAS_ADDR_LSB      1
`define CORE_CLK_KHZ        25000
`define REF_GAP_NS          20000
`define REF_GAP_CYC         ((`REF_GAP_NS * `CORE_CLK_KHZ) / 1000000)
`define STRAP_WAIT_CYC      2'h3
`endif

//--- shared/rx_port_cfg_pkg.sv
// types of the port setup bank
package rx_port_cfg_pkg;
  typedef enum logic [1:0] {
    FMT_CSI2     = 2'b00,
    FMT_RAW12_LO = 2'b01,
    FMT_RAW12_HI = 2'b10,
    FMT_RAW10    = 2'b11
  } link_input_format_e;
  typedef enum logic [1:0] {
    WCLK_REF = 2'b00,
    WCLK_SER = 2'b01,
    WCLK_PIX = 2'b10
  } wclk_src_e;
endpackage : rx_port_cfg_pkg

//--- tb/acc_host_model.sv
// host model issuing single-byte local and remote register accesses
`timescale 1ns/1ps
`default_nettype none
module acc_host_model (
  // clock
  input  wire logic        core_clk,
  // access request
  output logic             acc_valid,
  output logic             acc_write,
  output logic             acc_local,
  output logic [1:0]       acc_port,
  output logic [6:0]       acc_i2c_addr,
  output logic [7:0]       acc_reg,
  output logic [7:0]       acc_wdata
);
  initial begin
    acc_valid    = 1'b0;
    acc_write    = 1'b0;
    acc_local    = 1'b1;
    acc_port     = 2'h0;
    acc_i2c_addr = 7'h7F;
    acc_reg      = 8'hFF;
    acc_wdata    = 8'hFF;
  end
  // one access, held through its taking edge only
  task automatic xfer(input logic w, input logic loc, input logic [1:0] p,
                      input logic [6:0] a, input logic [7:0] r,
                      input logic [7:0] d);
    @(posedge core_clk);
    #1;
    acc_valid    = 1'b1;
    acc_write    = w;
    acc_local    = loc;
    acc_port     = p;
    acc_i2c_addr = a;
    acc_reg      = r;
    acc_wdata    = d;
    @(posedge core_clk);
    #1;
    acc_valid    = 1'b0;
    acc_i2c_addr = ~a;
    acc_reg      = ~r;
    acc_wdata    = ~d;
  endtask : xfer
endmodule : acc_host_model
`default_nettype wire

//--- tb/rx_port_cfg_tb.sv
// self-checking bench of the port setup bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin \
  cmp_count++; \
  if ((a) !== (b)) begin \
    mismatches++; \
    $display("Error t=%0t got %h exp %h", $time, (a), (b)); \
  end \
end
module rx_port_cfg_tb;
  import rx_port_cfg_pkg::*;
  localparam logic [6:0] DEV = 7'h30;
  logic        core_clk, sys_rst, reference_clock_in, ref_run;
  logic [2:0]  mode_strap;
  logic        acc_valid, acc_write, acc_local, acc_ack, acc_nak;
  logic [1:0]  acc_port;
  logic [6:0]  acc_i2c_addr;
  logic [7:0]  acc_reg, acc_wdata, acc_rdata, fwd_v;
  logic [3:0]  rx_input_en, fwd_en, port_raw_mode;
  logic [7:0]  link_input_format, wclk_src, wclk_div;
  logic [11:0] wclk_mul;
  logic        reference_clock_in_lost, use_ref_clk;
  logic [31:0] seed;
  logic [9:0]  exp_q[$], exp_v;
  int          mismatches, cmp_count;
  link_input_format_e lvl_fmt[8] = '{FMT_CSI2, FMT_RAW12_LO, FMT_RAW12_HI,
    FMT_RAW10, FMT_CSI2, FMT_RAW12_LO, FMT_RAW12_HI, FMT_RAW10};
  logic [7:0]  cfg[5] = '{8'h03, 8'h02, 8'h04, 8'h00, 8'h01};
  logic [1:0]  src[5] = '{2'h2, 2'h2, 2'h1, 2'h0, 2'h2};
  logic [2:0]  mul[5] = '{3'h1, 3'h2, 3'h2, 3'h4, 3'h1};
  logic [1:0]  div[5] = '{2'h2, 2'h3, 2'h1, 2'h1, 2'h1};

  rx_port_cfg #(.DEV_ADDR(DEV)) rx_port_cfg_i (
    .core_clk, .sys_rst, .mode_strap, .reference_clock_in, .acc_valid,
    .acc_write, .acc_local, .acc_port, .acc_i2c_addr, .acc_reg, .acc_wdata,
    .acc_ack, .acc_nak, .acc_rdata, .rx_input_en, .fwd_en, .port_raw_mode,
    .link_input_format, .wclk_src, .wclk_mul, .wclk_div, .reference_clock_in_lost,
    .use_ref_clk);
  acc_host_model acc_host_model_i (
    .core_clk, .acc_valid, .acc_write, .acc_local, .acc_port, .acc_i2c_addr,
    .acc_reg, .acc_wdata);

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // reference near 23.8 MHz, still while stopped
  initial begin
    reference_clock_in = 1'b0;
    forever #21 if (ref_run) reference_clock_in = ~reference_clock_in;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic test_done();
    if (mismatches == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done

  task automatic step();
    @(posedge core_clk);
    #1;
  endtask : step

  task automatic do_reset(input logic [2:0] s);
    sys_rst    = 1'b1;
    mode_strap = s;
    repeat (4) @(posedge core_clk);
    #1 sys_rst = 1'b0;
    repeat (5) step();
  endtask : do_reset

  task automatic acc(input logic w, input logic loc, input logic [1:0] p,
                     input logic [6:0] a, input logic [7:0] r,
                     input logic [7:0] d, input logic nak,
                     input logic [7:0] rd);
    exp_q.push_back({~nak, nak, rd});
    acc_host_model_i.xfer(w, loc, p, a, r, d);
  endtask : acc

  // answer watcher
  always @(posedge core_clk) begin
    #2;
    if (acc_ack === 1'b1 || acc_nak === 1'b1) begin
      if (exp_q.size() == 0) begin
        mismatches++;
        $display("Error t=%0t got %h exp none", $time, acc_rdata);
      end
      else begin
        exp_v = exp_q.pop_front();
        `CHK({acc_ack, acc_nak, acc_rdata}, exp_v)
      end
    end
  end

  initial begin
    #200000;
    mismatches++;
    test_done();
  end

  initial begin
    sys_rst    = 1'b1;
    mode_strap = 3'h0;
    ref_run    = 1'b0;
    seed       = 32'd38;
    mismatches = 0;
    cmp_count  = 0;
    for (int s = 0; s < 8; s++) begin
      do_reset(s[2:0]);
      `CHK(link_input_format, {4{lvl_fmt[s]}})
      `CHK(port_raw_mode, {4{lvl_fmt[s] != FMT_CSI2}})
      acc(0, 1, 0, DEV, 8'h6D, 8'h00, 0, {6'h0, lvl_fmt[s]});
    end
    `CHK(rx_input_en, 4'hF)
    `CHK(fwd_en, 4'h0)
    `CHK({use_ref_clk, reference_clock_in_lost}, 2'b01)
    acc(0, 1, 0, DEV, 8'h0C, 8'h00, 0, 8'h0F);
    acc(0, 1, 0, DEV, 8'h20, 8'h00, 0, 8'h00);
    for (int p = 0; p < 4; p++)
      acc(0, 0, p, DEV, 8'h4C, 8'h00, 0, {2'h0, p[1:0], 4'(1 << p)});
    acc(1, 0, 2, DEV, 8'h0C, 8'h00, 0, 8'h00);
    acc(0, 1, 0, DEV, 8'h0C, 8'h00, 0, 8'h0F);
    acc(1, 1, 0, DEV, 8'h0C, 8'h05, 0, 8'h00);
    step();
    `CHK(rx_input_en, 4'h5)
    fwd_v = rnd() & 8'h0F;
    acc(1, 1, 0, DEV, 8'h20, fwd_v, 0, 8'h00);
    step();
    `CHK(fwd_en, fwd_v[3:0])
    acc(1, 1, 0, DEV, 8'h4C, 8'h24, 0, 8'h00);
    for (int i = 0; i < 5; i++) begin
      acc(1, 1, 0, DEV, 8'h6D, cfg[i], 0, 8'h00);
      step();
      `CHK(wclk_src[5:4], src[i])
      `CHK(wclk_mul[8:6], mul[i])
      `CHK(wclk_div[5:4], div[i])
      `CHK(link_input_format[5:4], cfg[i][1:0])
    end
    `CHK(link_input_format, 8'hDF)
    acc(0, 1, 0, DEV, 8'h6D, 8'h00, 0, 8'h01);
    acc(1, 1, 0, DEV, 8'hF9, 8'hA4, 0, 8'h00);
    acc(0, 1, 0, 7'h52, 8'h6D, 8'h00, 0, 8'h03);
    acc(1, 1, 0, 7'h52, 8'h6D, 8'h02, 0, 8'h00);
    acc(0, 1, 0, 7'h52, 8'h0C, 8'h00, 0, 8'h05);
    acc(0, 1, 0, 7'h52, 8'hF9, 8'h00, 0, 8'hA4);
    acc(0, 1, 0, 7'h11, 8'h0C, 8'h00, 1, 8'h00);
    acc(0, 1, 0, 7'h00, 8'h0C, 8'h00, 1, 8'h00);
    acc(0, 1, 0, DEV, 8'h55, 8'h00, 0, 8'h00);
    `CHK(link_input_format, 8'hDB)
    ref_run = 1'b1;
    repeat (20) step();
    `CHK({use_ref_clk, reference_clock_in_lost}, 2'b10)
    ref_run = 1'b0;
    repeat (490) step();
    `CHK(reference_clock_in_lost, 1'b0)
    repeat (20) step();
    `CHK({use_ref_clk, reference_clock_in_lost}, 2'b01)
    for (int i = 0; i < 10 && exp_q.size() != 0; i++) step();
    if (exp_q.size() != 0) mismatches++;
    test_done();
  end
endmodule : rx_port_cfg_tb
`default_nettype wire
